/* design/fpe_pkg.sv */
// Constants and types shared by the flash sequencer files
package fpe_pkg;
  // Register byte offsets on the bus
  localparam logic [4:0] FPE_OFF_CTRL = 5'h00;
  localparam logic [4:0] FPE_OFF_BOUND = 5'h04;
  localparam logic [4:0] FPE_OFF_FADDR = 5'h08;
  localparam logic [4:0] FPE_OFF_FDATA = 5'h0C;
  localparam logic [4:0] FPE_OFF_STATUS = 5'h10;
  // Control register field positions
  localparam int FPE_CTRL_WRITE = 0;
  localparam int FPE_CTRL_CLEAR = 1;
  localparam int FPE_CTRL_WHOLE = 2;
  localparam int FPE_CTRL_HV = 3;
  // Reset values
  localparam logic [3:0] FPE_CTRL_RST = 4'h0;
  localparam logic [15:0] FPE_FADDR_RST = 16'h0000;
  localparam logic [7:0] FPE_FDATA_RST = 8'h00;
  // Protection encoding
  localparam logic [7:0] FPE_BOUND_OPEN = 8'hFF;
  localparam logic [7:0] FPE_BOUND_ALL_MAX = 8'h77;
  localparam logic [1:0] FPE_START_TOP = 2'h3;
  localparam logic [5:0] FPE_START_LOW = 6'h00;
  localparam logic [15:0] FPE_BOUND_ADDR = 16'hFFBE;
  localparam logic [15:0] FPE_TRIM_ADDR = 16'hFFC0;
  // Page of 64 bytes, row of 32 bytes
  localparam int FPE_PAGE_BITS = 6;
  localparam int FPE_ROW_BITS = 5;
  // Sequence states, Gray coded along the usual path
  typedef enum logic [2:0] {
    FPE_ST_IDLE = 3'h0,
    FPE_ST_SEL = 3'h1,
    FPE_ST_BREAD = 3'h3,
    FPE_ST_LATCH = 3'h2,
    FPE_ST_HV = 3'h6
  } fpe_state_t;
endpackage

/* design/fpe_prot_if.sv */
// Signals between the sequencer and its protection checker
`timescale 1ns/100ps
`default_nettype none
interface fpe_prot_if;
  logic [7:0] boundary;
  logic [15:0] target;
  logic whole;
  logic test_hv;
  logic allowed;
  modport req (output boundary, output target, output whole, output test_hv, input allowed);
  modport chk (input boundary, input target, input whole, input test_hv, output allowed);
endinterface
`default_nettype wire

/* design/fpe_prot_check.sv */
// Protection checker for a page, row or whole-array target
`timescale 1ns/100ps
`default_nettype none
module fpe_prot_check (
  fpe_prot_if.chk pif
);
  import fpe_pkg::*;
  logic [15:0] start;
  logic open_all;
  logic lock_all;
  logic in_range;
  logic bound_hit;

  always_comb begin
    start = {FPE_START_TOP, pif.boundary, FPE_START_LOW};
    open_all = (pif.boundary == FPE_BOUND_OPEN);
    lock_all = (pif.boundary <= FPE_BOUND_ALL_MAX);
    in_range = lock_all || (pif.target >= start);
    bound_hit = (pif.target[15:FPE_PAGE_BITS] == FPE_BOUND_ADDR[15:FPE_PAGE_BITS]);
    if (pif.whole) begin
      pif.allowed = open_all;
    end else if (open_all || pif.test_hv) begin
      pif.allowed = 1'b1;
    end else begin
      pif.allowed = !in_range && !bound_hit;
    end
  end
endmodule
`default_nettype wire

/* design/fpe_flash_seq.sv */
// Flash program and erase sequencer with block protection, AHB-Lite slave
// Notes on behaviour
// - Whole-array bit selects full erase
// - Clear and write selects never both set
// - Erase page is 64 aligned bytes
// - Dummy write address picks erased page
// - Full erase only when boundary all ones; not checked when the whole bit is set with or after the HV request
// - Program row is 32 aligned bytes
// - Write select latches program address, data
// - Vector page erase clears trim byte
// - Protected range refuses high voltage
// - Start address from boundary bits
// - Low values lock all, ones none
// - Test voltage overrides boundary protection, except for full erase
// - Boundary lives in flash, reset-proof
// - High voltage needs select and sequence
`timescale 1ns/100ps
`default_nettype none
module fpe_flash_seq (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [7:0] boundary_bits,
  input wire logic test_high_voltage,
  output logic [15:0] arr_addr,
  output logic [7:0] arr_wdata,
  output logic arr_we,
  output logic [15:0] arr_erase_base,
  output logic arr_write_op,
  output logic arr_clear_op,
  output logic arr_whole,
  output logic arr_high_voltage,
  output logic arr_trim_clear
);
  import fpe_pkg::*;

  fpe_prot_if pif ();

  fpe_state_t state_r;
  logic write_op_select_r;
  logic clear_op_select_r;
  logic whole_array_select_r;
  logic high_voltage_enable_r;
  logic [15:0] faddr_r;
  logic [7:0] fdata_r;
  logic [15:0] latch_addr_r;
  logic [7:0] latch_data_r;
  logic we_r;
  logic tvh_meta_r;
  logic tvh_sync_r;
  logic dp_rd_r;
  logic dp_wr_r;
  logic rd_ready_r;
  logic [4:0] dp_addr_r;
  logic [31:0] hrdata_r;
  logic [31:0] rd_mux;
  logic accept;
  logic wr_ctrl;
  logic wr_faddr;
  logic wr_fdata;
  logic rd_load;
  logic rd_bound;
  logic any_select;
  logic nxt_write;
  logic nxt_clear;
  logic nxt_whole;
  logic hv_req;
  logic hv_grant;

  // Bus handshake: reads take one wait state so data leaves a flop
  assign accept = hsel && htrans[1] && hready;
  assign hreadyout = !(dp_rd_r && !rd_ready_r);
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;
  assign rd_load = dp_rd_r && !rd_ready_r;
  assign rd_bound = rd_load && (dp_addr_r == FPE_OFF_BOUND);
  assign wr_ctrl = dp_wr_r && (dp_addr_r == FPE_OFF_CTRL);
  assign wr_faddr = dp_wr_r && (dp_addr_r == FPE_OFF_FADDR);
  assign wr_fdata = dp_wr_r && (dp_addr_r == FPE_OFF_FDATA);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_rd_r <= 1'b0;
      dp_wr_r <= 1'b0;
      dp_addr_r <= 5'h00;
    end else if (hready) begin
      dp_rd_r <= accept && !hwrite;
      dp_wr_r <= accept && hwrite && (hsize == 3'h2);
      dp_addr_r <= accept ? {haddr[4:2], 2'h0} : dp_addr_r;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_ready_r <= 1'b0;
    end else if (rd_load) begin
      rd_ready_r <= 1'b1;
    end else if (hready) begin
      rd_ready_r <= 1'b0;
    end
  end

  // Read multiplexer; unmapped offsets read as zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (dp_addr_r)
      FPE_OFF_CTRL: begin
        rd_mux[FPE_CTRL_WRITE] = write_op_select_r;
        rd_mux[FPE_CTRL_CLEAR] = clear_op_select_r;
        rd_mux[FPE_CTRL_WHOLE] = whole_array_select_r;
        rd_mux[FPE_CTRL_HV] = high_voltage_enable_r;
      end
      FPE_OFF_BOUND: rd_mux[7:0] = boundary_bits;
      FPE_OFF_FADDR: rd_mux[15:0] = faddr_r;
      FPE_OFF_FDATA: rd_mux[7:0] = fdata_r;
      FPE_OFF_STATUS: rd_mux[4:0] = {pif.allowed, tvh_sync_r, state_r};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= 32'h0000_0000;
    end else if (rd_load) begin
      hrdata_r <= rd_mux;
    end
  end

  // Test voltage pin is asynchronous
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tvh_meta_r <= 1'b0;
      tvh_sync_r <= 1'b0;
    end else begin
      tvh_meta_r <= test_high_voltage;
      tvh_sync_r <= tvh_meta_r;
    end
  end

  // Protection check on the latched target
  assign pif.boundary = boundary_bits;
  assign pif.target = latch_addr_r;
  assign pif.whole = whole_array_select_r;
  assign pif.test_hv = tvh_sync_r;

  fpe_prot_check u_check (
    .pif(pif)
  );

  // Select bits with interlock: a write asking for both leaves the write and clear selects unchanged
  always_comb begin
    nxt_write = write_op_select_r;
    nxt_clear = clear_op_select_r;
    nxt_whole = whole_array_select_r;
    hv_req = high_voltage_enable_r;
    if (wr_ctrl) begin
      nxt_whole = hwdata[FPE_CTRL_WHOLE];
      hv_req = hwdata[FPE_CTRL_HV];
      if (!(hwdata[FPE_CTRL_WRITE] && hwdata[FPE_CTRL_CLEAR])) begin
        nxt_write = hwdata[FPE_CTRL_WRITE] && !clear_op_select_r;
        nxt_clear = hwdata[FPE_CTRL_CLEAR] && !write_op_select_r;
        if (hwdata[FPE_CTRL_WRITE] && !hwdata[FPE_CTRL_CLEAR]) begin
          nxt_clear = 1'b0;
          nxt_write = 1'b1;
        end
        if (hwdata[FPE_CTRL_CLEAR] && !hwdata[FPE_CTRL_WRITE]) begin
          nxt_write = 1'b0;
          nxt_clear = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      write_op_select_r <= FPE_CTRL_RST[FPE_CTRL_WRITE];
      clear_op_select_r <= FPE_CTRL_RST[FPE_CTRL_CLEAR];
      whole_array_select_r <= FPE_CTRL_RST[FPE_CTRL_WHOLE];
    end else if (wr_ctrl) begin
      write_op_select_r <= nxt_write;
      clear_op_select_r <= nxt_clear;
      whole_array_select_r <= nxt_whole;
    end
  end

  assign any_select = nxt_write || nxt_clear;

  // High voltage only once the sequence reached the latched step and the
  // target is not protected; a refused request simply leaves it low
  assign hv_grant = (state_r == FPE_ST_LATCH) && any_select && pif.allowed;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      high_voltage_enable_r <= FPE_CTRL_RST[FPE_CTRL_HV];
    end else if (wr_ctrl) begin
      if (!hv_req) begin
        high_voltage_enable_r <= 1'b0;
      end else if (!high_voltage_enable_r) begin
        high_voltage_enable_r <= hv_grant;
      end
    end
  end

  // Sequence tracker
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= FPE_ST_IDLE;
    end else begin
      case (state_r)
        FPE_ST_IDLE: begin
          if (wr_ctrl && any_select) begin
            state_r <= FPE_ST_SEL;
          end
        end
        FPE_ST_SEL: begin
          if (wr_ctrl && !any_select) begin
            state_r <= FPE_ST_IDLE;
          end else if (rd_bound) begin
            state_r <= FPE_ST_BREAD;
          end
        end
        FPE_ST_BREAD: begin
          if (wr_ctrl && !any_select) begin
            state_r <= FPE_ST_IDLE;
          end else if (wr_fdata) begin
            state_r <= FPE_ST_LATCH;
          end
        end
        FPE_ST_LATCH: begin
          if (wr_ctrl && !any_select) begin
            state_r <= FPE_ST_IDLE;
          end else if (wr_ctrl && hv_req && hv_grant) begin
            state_r <= FPE_ST_HV;
          end
        end
        FPE_ST_HV: begin
          if (wr_ctrl && !hv_req) begin
            state_r <= any_select ? FPE_ST_SEL : FPE_ST_IDLE;
          end
        end
        default: state_r <= FPE_ST_IDLE;
      endcase
    end
  end

  // Software-owned flash address and data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      faddr_r <= FPE_FADDR_RST;
    end else if (wr_faddr) begin
      faddr_r <= hwdata[15:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fdata_r <= FPE_FDATA_RST;
    end else if (wr_fdata) begin
      fdata_r <= hwdata[7:0];
    end
  end

  // Setup write picks the target; program writes under high voltage
  // are latched and passed to the array one byte at a time
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      latch_addr_r <= FPE_FADDR_RST;
      latch_data_r <= FPE_FDATA_RST;
      we_r <= 1'b0;
    end else begin
      we_r <= 1'b0;
      if (wr_fdata && (state_r == FPE_ST_BREAD)) begin
        latch_addr_r <= faddr_r;
        latch_data_r <= hwdata[7:0];
      end else if (wr_fdata && (state_r == FPE_ST_HV) && write_op_select_r) begin
        latch_addr_r <= {latch_addr_r[15:FPE_ROW_BITS], faddr_r[FPE_ROW_BITS-1:0]};
        latch_data_r <= hwdata[7:0];
        we_r <= 1'b1;
      end
    end
  end

  // Array drive; programming writes stay inside the setup row
  assign arr_addr = latch_addr_r;
  assign arr_wdata = latch_data_r;
  assign arr_we = we_r;
  assign arr_erase_base = {latch_addr_r[15:FPE_PAGE_BITS], FPE_START_LOW};
  assign arr_write_op = write_op_select_r;
  assign arr_clear_op = clear_op_select_r;
  assign arr_whole = whole_array_select_r;
  assign arr_high_voltage = high_voltage_enable_r;
  // Vector page holds the trim byte
  assign arr_trim_clear = high_voltage_enable_r && clear_op_select_r && (whole_array_select_r
    || (arr_erase_base == FPE_TRIM_ADDR));
endmodule
`default_nettype wire

/* tb/fpe_flash_seq_monitor.sv */
// Port assertions for the flash sequencer
`timescale 1ns/100ps
`default_nettype none
module fpe_flash_seq_monitor (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic [7:0] boundary_bits,
  input wire logic test_high_voltage,
  input wire logic [15:0] arr_addr,
  input wire logic arr_we,
  input wire logic [15:0] arr_erase_base,
  input wire logic arr_write_op,
  input wire logic arr_clear_op,
  input wire logic arr_whole,
  input wire logic arr_high_voltage,
  input wire logic arr_trim_clear
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic bread;
  logic hv_up;
  assign bread = hsel && htrans[1] && hready && !hwrite && haddr[4:0] == 5'h04;
  assign hv_up = arr_high_voltage && !arr_trim_clear;
  sel_excl_a: assert property (!(arr_write_op && arr_clear_op))
    else $error("both selects high");
  hv_sel_a: assert property ($rose(arr_high_voltage) |-> arr_write_op || arr_clear_op)
    else $error("high voltage without select");
  hv_whole_a: assert property ($rose(arr_high_voltage) && arr_whole |-> boundary_bits == 8'hFF)
    else $error("full erase while protected");
  hv_low_a: assert property ($rose(arr_high_voltage) && boundary_bits <= 8'h77
    |-> $past(test_high_voltage, 3)) else $error("high voltage with all locked");
  hv_range_a: assert property ($rose(arr_high_voltage) && boundary_bits != 8'hFF
    && !$past(test_high_voltage, 3) |-> arr_addr < {2'b11, boundary_bits, 6'h00})
    else $error("high voltage inside protected range");
  page_base_a: assert property (arr_erase_base[5:0] == 6'h00)
    else $error("erase base not page aligned");
  trim_a: assert property (arr_high_voltage && arr_clear_op
    && (arr_whole || arr_erase_base == 16'hFFC0) |-> arr_trim_clear) else $error("trim kept");
  we_pulse_a: assert property (arr_we |-> arr_write_op ##1 !arr_we)
    else $error("array write outside program");
  bound_rd_a: assert property (bread |=> ##1 hrdata[7:0] == boundary_bits)
    else $error("boundary read wrong");
  cover property ($rose(arr_high_voltage) && arr_whole);
  cover property ($rose(arr_high_voltage) && arr_write_op);
  cover property (arr_we);
  cover property (hv_up && arr_clear_op);
endmodule
bind fpe_flash_seq fpe_flash_seq_monitor fpe_flash_seq_monitor_inst (.hclk, .hresetn, .hsel,
  .haddr, .htrans, .hwrite, .hready, .hrdata, .boundary_bits, .test_high_voltage, .arr_addr,
  .arr_we, .arr_erase_base, .arr_write_op, .arr_clear_op, .arr_whole, .arr_high_voltage,
  .arr_trim_clear);
`default_nettype wire

/* tb/fpe_flash_seq_bench.sv */
// Self-checking bench for the flash sequencer
`timescale 1ns/100ps
`default_nettype none
module fpe_flash_seq_bench;
  import fpe_pkg::*;
  typedef struct {logic [7:0] b; logic t; logic [3:0] op; logic [15:0] a; logic hv;} fpe_row_t;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic test_high_voltage = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [7:0] boundary_bits = 8'hFF;
  logic hready, hreadyout, hresp, arr_we, arr_write_op, arr_clear_op, arr_whole;
  logic arr_high_voltage, arr_trim_clear, tr;
  logic [31:0] hrdata, rd;
  logic [15:0] arr_addr, arr_erase_base;
  logic [7:0] arr_wdata;
  int mismatches = 0;
  int samples_checked = 0;
  fpe_row_t rows [14] = '{
    '{8'hFF, 1'b0, 4'h2, 16'h1234, 1'b1}, '{8'hFF, 1'b0, 4'h6, 16'h8000, 1'b1},
    '{8'hFE, 1'b0, 4'h6, 16'h8000, 1'b0}, '{8'hFE, 1'b1, 4'h6, 16'h8000, 1'b0},
    '{8'h78, 1'b0, 4'h2, 16'hDDC0, 1'b1}, '{8'h78, 1'b0, 4'h2, 16'hDE00, 1'b0},
    '{8'h00, 1'b0, 4'h1, 16'h0100, 1'b0}, '{8'h77, 1'b0, 4'h1, 16'h0100, 1'b0},
    '{8'h77, 1'b1, 4'h1, 16'h0100, 1'b1}, '{8'hFF, 1'b0, 4'h2, 16'hFFC0, 1'b1},
    '{8'hFE, 1'b0, 4'h2, 16'hFFC0, 1'b0}, '{8'hDF, 1'b0, 4'h1, 16'hF7A0, 1'b1},
    '{8'hDF, 1'b0, 4'h1, 16'hF7C0, 1'b0}, '{8'hFE, 1'b1, 4'h2, 16'hFF80, 1'b1}};
  assign hready = hreadyout;
  always #10 hclk = ~hclk;
  fpe_flash_seq fpe_flash_seq_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hreadyout, .hresp, .hrdata, .boundary_bits, .test_high_voltage,
    .arr_addr, .arr_wdata, .arr_we, .arr_erase_base, .arr_write_op, .arr_clear_op, .arr_whole,
    .arr_high_voltage, .arr_trim_clear);
  task automatic close_out;
    if (mismatches == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  // One word transfer; read data lands in rd
  task automatic xfer(input logic w, input logic [4:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {27'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
    // Idle cycle so effects launched at the answer edge are settled
    @(posedge hclk);
  endtask
  task automatic run_seq(input fpe_row_t r);
    boundary_bits <= r.b;
    test_high_voltage <= r.t;
    repeat (4) @(posedge hclk);
    xfer(1'b1, FPE_OFF_CTRL, {28'h0, r.op});
    xfer(1'b0, FPE_OFF_BOUND, 32'h0);
    chk("boundary", {24'h0, r.b}, rd);
    xfer(1'b1, FPE_OFF_FADDR, {16'h0, r.a});
    xfer(1'b1, FPE_OFF_FDATA, 32'h5A);
    xfer(1'b1, FPE_OFF_CTRL, {28'h0, r.op | 4'h8});
    xfer(1'b0, FPE_OFF_CTRL, 32'h0);
    chk("hv bit", {28'h0, r.op | {r.hv, 3'h0}}, rd);
    chk("ops", {29'h0, r.op[2:0]}, {29'h0, arr_whole, arr_clear_op, arr_write_op});
    chk("resp", 32'h0, {31'h0, hresp});
    chk("hv pin", {31'h0, r.hv}, {31'h0, arr_high_voltage});
    chk("base", {16'h0, r.a & 16'hFFC0}, {16'h0, arr_erase_base});
    tr = r.hv && r.op[1] && (r.op[2] || r.a[15:6] == 10'h3FF);
    chk("trim", {31'h0, tr}, {31'h0, arr_trim_clear});
    if (r.op[0] && r.hv) begin
      xfer(1'b1, FPE_OFF_FADDR, {16'h0, r.a + 16'h1});
      xfer(1'b1, FPE_OFF_FDATA, 32'hA5);
      chk("prog we", 32'h1, {31'h0, arr_we});
      chk("prog addr", {16'h0, r.a + 16'h1}, {16'h0, arr_addr});
      chk("prog data", 32'hA5, {24'h0, arr_wdata});
      xfer(1'b1, FPE_OFF_FADDR, {16'h0, r.a + 16'h22});
      xfer(1'b1, FPE_OFF_FDATA, 32'h3C);
      chk("row kept", {16'h0, r.a + 16'h2}, {16'h0, arr_addr});
    end
    xfer(1'b1, FPE_OFF_CTRL, {28'h0, r.hv, 3'h0});
    xfer(1'b1, FPE_OFF_CTRL, 32'h0);
    chk("hv off", 32'h0, {31'h0, arr_high_voltage});
  endtask
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    xfer(1'b0, FPE_OFF_CTRL, 32'h0);
    chk("ctrl reset", 32'h0, rd);
    foreach (rows[i]) run_seq(rows[i]);
    boundary_bits <= 8'hFF;
    test_high_voltage <= 1'b0;
    xfer(1'b1, FPE_OFF_CTRL, 32'h1);
    xfer(1'b1, FPE_OFF_CTRL, 32'h3);
    xfer(1'b0, FPE_OFF_CTRL, 32'h0);
    chk("interlock", 32'h1, rd);
    xfer(1'b1, FPE_OFF_CTRL, 32'h9);
    xfer(1'b0, FPE_OFF_CTRL, 32'h0);
    chk("early hv", 32'h1, rd);
    xfer(1'b1, FPE_OFF_CTRL, 32'h0);
    xfer(1'b1, FPE_OFF_CTRL, 32'h3);
    xfer(1'b0, FPE_OFF_CTRL, 32'h0);
    chk("both set", 32'h0, rd);
    xfer(1'b1, FPE_OFF_CTRL, 32'h4);
    xfer(1'b0, FPE_OFF_CTRL, 32'h0);
    chk("whole bit", 32'h4, rd);
    xfer(1'b0, 5'h14, 32'h0);
    chk("unmapped", 32'h0, rd);
    // Reset while high voltage is on
    xfer(1'b1, FPE_OFF_CTRL, 32'h2);
    xfer(1'b0, FPE_OFF_BOUND, 32'h0);
    xfer(1'b1, FPE_OFF_FADDR, 32'h4000);
    xfer(1'b1, FPE_OFF_FDATA, 32'h0);
    xfer(1'b1, FPE_OFF_CTRL, 32'hA);
    chk("hv before reset", 32'h1, {31'h0, arr_high_voltage});
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    chk("hv in reset", 32'h0, {31'h0, arr_high_voltage});
    hresetn <= 1'b1;
    @(posedge hclk);
    xfer(1'b0, FPE_OFF_BOUND, 32'h0);
    chk("boundary kept", 32'hFF, rd);
    close_out;
  end
  initial begin
    repeat (5000) @(posedge hclk);
    mismatches++;
    close_out;
  end
endmodule
`default_nettype wire
